// file: src/rfpx_extractor.v
// Packet extractor working on checked frame payload rows.
// Assumes the decoder delivers rows one byte per in_valid cycle,
// header first, and flags frame starts and losses as pulses.
`timescale 1ns/1ns
`default_nettype none
`include "rfpx_map.vh"

// Function
// - Rows whose header error flag is set are dropped without extracting anything.
// - A packet wrapped from a full 187-row frame continues when rows up to the next one of its type are all clean.
// - Resynchronization follows ensemble selection, a lost frame or a lost row of any type.
// - Any errored row forces every protocol type to resynchronize after it.
// - Resync scans rows until one whose pointer is not the no-packet code.
// - In that row the pointer bytes are skipped and a new packet starts there.
// - Once synchronized each next packet start follows from the packet length field, across rows and frames.
// - A missing row or frame drops the current packet position and forces resync.
// - Stuffing bytes signalled in a row header are skipped and never output.
// - Each row begins with a two-byte header of type, error flag, stuffing flag and 11-bit pointer.
// - A frame payload holds 187 rows of a configurable width.
// - Stuffing sits at the row start, coded as 0xFF, 0xFEFF or a count below 0xFEFF.
// - Packets lie end to end and wrap only into the next row of the same type.
module rfpx_extractor #(
    parameter NTYPES = 8
) (
    input  wire              clk_sys,
    input  wire              rst_n,
    input  wire              in_valid,
    input  wire [7:0]        in_data,
    input  wire              in_row_start,
    input  wire              in_frame_start,
    input  wire              in_frame_lost,
    input  wire              in_row_missing,
    input  wire              ens_select,
    output reg               out_valid,
    output reg  [7:0]        out_data,
    output reg               out_sop,
    output reg               out_eop,
    output reg  [2:0]        out_proto,
    output reg  [NTYPES-1:0] out_abort,
    output wire [NTYPES-1:0] sync_state
);
    // ----------------------------------------
    // Row parsing
    // ----------------------------------------
    wire        hdr_end;
    wire [2:0]  row_proto;
    wire        row_err;
    wire [10:0] row_ptr;
    wire        pay_valid;
    wire [15:0] pay_pos;

    // Parser hides header and stuffing bytes from the decision below
    // header layout decode
    rfpx_row_parser u_parser (
        .clk_sys      (clk_sys),
        .rst_n        (rst_n),
        .in_valid     (in_valid),
        .in_data      (in_data),
        .in_row_start (in_row_start),
        .hdr_end      (hdr_end),
        .row_proto    (row_proto),
        .row_err      (row_err),
        .row_ptr      (row_ptr),
        .pay_valid    (pay_valid),
        .pay_pos      (pay_pos)
    );

    // ----------------------------------------
    // Per-type context
    // ----------------------------------------
    // Kept per type since rows of different types interleave
    // rem_reg: bytes left after the length field
    // idx_reg: byte index up to the length field
    reg [NTYPES-1:0] sync_reg;
    reg [NTYPES-1:0] inpkt_reg;
    reg [15:0]       rem_reg [0:NTYPES-1];
    reg [2:0]        idx_reg [0:NTYPES-1];
    reg [7:0]        lenhi_reg [0:NTYPES-1];
    reg              rowbad_reg;
    reg [7:0]        rowcnt_reg;
    integer          i;

    assign sync_state = sync_reg;

    // ----------------------------------------
    // Loss detection
    // ----------------------------------------
    wire row_lost;
    wire short_frame;
    wire desync;

    assign row_lost = hdr_end && row_err;
    // Besides in_row_missing, the row count shows a row dropped inside a frame
    // short frame means a missing row
    assign short_frame = in_valid && in_frame_start && in_row_start && (rowcnt_reg != `RFPX_ROWS)
                         && (rowcnt_reg != 8'h00);
    // Loss beats a byte taken in the same cycle
    // every loss source resyncs
    assign desync = row_lost || short_frame || in_frame_lost || in_row_missing || ens_select;

    // ----------------------------------------
    // Byte decision for the current type
    // ----------------------------------------
    wire [2:0]  t;
    wire        tsync;
    wire        start;
    wire        take;
    wire [2:0]  cur_idx;
    wire [15:0] len;
    wire        ptr_hit;

    assign t       = row_proto;
    assign tsync   = sync_reg[t];
    // Pointer only matters while the type is unsynced
    // resync waits for a real pointer
    assign ptr_hit = (row_ptr != `RFPX_PTR_NONE) && (pay_pos == {5'h00, row_ptr});
    assign start   = tsync ? !inpkt_reg[t] : ptr_hit;
    // No back-pressure: a refused byte is simply lost
    // nothing taken from bad row
    assign take    = pay_valid && !rowbad_reg && !desync && (start || inpkt_reg[t]);
    assign cur_idx = start ? 3'h0 : idx_reg[t];
    assign len     = {lenhi_reg[t], in_data};

    // ----------------------------------------
    // Row bookkeeping
    // ----------------------------------------
    // Count just wraps if frame starts stop; the next one reloads it
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            rowbad_reg <= 1'b0;
            rowcnt_reg <= 8'h00;
        end else begin
            if (in_valid && in_row_start) begin
                rowbad_reg <= 1'b0;
                rowcnt_reg <= in_frame_start ? 8'h01 : rowcnt_reg + 8'h01;
            end
            if (row_lost)
                rowbad_reg <= 1'b1;
        end
    end

    // ----------------------------------------
    // Per-type packet tracking
    // ----------------------------------------
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            sync_reg   <= {NTYPES{1'b0}};
            inpkt_reg  <= {NTYPES{1'b0}};
            out_valid  <= 1'b0;
            out_data   <= 8'h00;
            out_sop    <= 1'b0;
            out_eop    <= 1'b0;
            out_proto  <= 3'h0;
            out_abort  <= {NTYPES{1'b0}};
            for (i = 0; i < NTYPES; i = i + 1) begin
                rem_reg[i]   <= 16'h0000;
                idx_reg[i]   <= 3'h0;
                lenhi_reg[i] <= 8'h00;
            end
        end else begin
            // Valid, sop, eop and abort are one-cycle pulses unless set below; out_data and out_proto hold
            out_valid <= 1'b0;
            out_sop   <= 1'b0;
            out_eop   <= 1'b0;
            out_abort <= {NTYPES{1'b0}};
            // Open packets cannot finish once a row is gone
            if (desync) begin
                sync_reg  <= {NTYPES{1'b0}};
                inpkt_reg <= {NTYPES{1'b0}};
                out_abort <= inpkt_reg;
            end else if (take) begin
                out_valid <= 1'b1;
                out_data  <= in_data;
                out_sop   <= start;
                out_proto <= t;
                sync_reg[t]  <= 1'b1;
                inpkt_reg[t] <= 1'b1;
                if (cur_idx != `RFPX_LEN_DONE_IDX)
                    idx_reg[t] <= cur_idx + 3'h1;
                // High length byte waits for the low one
                if (cur_idx == `RFPX_LEN_HI_IDX)
                    lenhi_reg[t] <= in_data;
                // Length includes the four bytes already passed
                // length sets next boundary
                if (cur_idx == `RFPX_LEN_LO_IDX) begin
                    if (len < `RFPX_LEN_MIN) begin
                        // Bad length cannot be trusted; resync this type
                        sync_reg[t]  <= 1'b0;
                        inpkt_reg[t] <= 1'b0;
                        out_abort[t] <= 1'b1;
                    end else begin
                        rem_reg[t] <= len - `RFPX_LEN_MIN;
                        if (len == `RFPX_LEN_MIN) begin
                            out_eop      <= 1'b1;
                            inpkt_reg[t] <= 1'b0;
                        end
                    end
                end else if (cur_idx == `RFPX_LEN_DONE_IDX) begin
                    // Last byte is the one that finds a count of one
                    rem_reg[t] <= rem_reg[t] - 16'h0001;
                    if (rem_reg[t] == 16'h0001) begin
                        out_eop      <= 1'b1;
                        inpkt_reg[t] <= 1'b0;
                    end
                end
            end
        end
    end
endmodule // rfpx_extractor

`default_nettype wire

// file: src/rfpx_map.vh
// Constants for the frame packet extractor: row header layout,
// stuffing codes, packet length field and frame geometry.
// Assumes nothing; definitions only.
`ifndef RFPX_MAP_VH
`define RFPX_MAP_VH

// ----------------------------------------
// Row header fields (first header byte)
// ----------------------------------------
`define RFPX_HDR_PROTO_MSB  7
`define RFPX_HDR_PROTO_LSB  5
`define RFPX_HDR_ERR_BIT    4
`define RFPX_HDR_STUFF_BIT  3
`define RFPX_HDR_PTRHI_MSB  2
`define RFPX_HDR_PTRHI_LSB  0
`define RFPX_PTR_NONE       11'h7ff

// ----------------------------------------
// Stuffing codes
// ----------------------------------------
`define RFPX_STUFF_ONE      8'hff
`define RFPX_STUFF_TWO      16'hfeff
`define RFPX_STUFF_TWO_CNT  16'h0002

// ----------------------------------------
// Packet length field and frame geometry
// ----------------------------------------
`define RFPX_LEN_HI_IDX     3'h2
`define RFPX_LEN_LO_IDX     3'h3
`define RFPX_LEN_DONE_IDX   3'h4
`define RFPX_LEN_MIN        16'h0004
`define RFPX_ROWS           8'hbb

`endif

// file: src/rfpx_row_parser.v
// Row header and stuffing parser for one payload row stream.
// Assumes bytes arrive one per in_valid cycle, the row header first,
// with in_row_start marking the first header byte.
`timescale 1ns/1ns
`default_nettype none
`include "rfpx_map.vh"

module rfpx_row_parser (
    input  wire        clk_sys,
    input  wire        rst_n,
    input  wire        in_valid,
    input  wire [7:0]  in_data,
    input  wire        in_row_start,
    output wire        hdr_end,
    output wire [2:0]  row_proto,
    output wire        row_err,
    output wire [10:0] row_ptr,
    output wire        pay_valid,
    output wire [15:0] pay_pos
);
    // ----------------------------------------
    // Phase: one-hot header/payload
    // ----------------------------------------
    localparam PH_IDLE = 3'b001;
    localparam PH_HDR1 = 3'b010;
    localparam PH_PAY  = 3'b100;

    reg [2:0]  ph_reg;
    reg [2:0]  ph_next;
    reg [7:0]  hb0_reg;
    reg [7:0]  hb1_reg;
    reg [15:0] pos_reg;
    reg [7:0]  s0_reg;
    reg [15:0] sn_reg;
    reg        stuff;

    wire       stf_flag;
    wire [15:0] pair;

    assign row_proto = hb0_reg[`RFPX_HDR_PROTO_MSB:`RFPX_HDR_PROTO_LSB];
    assign row_err   = hb0_reg[`RFPX_HDR_ERR_BIT];
    assign stf_flag  = hb0_reg[`RFPX_HDR_STUFF_BIT];
    assign row_ptr   = {hb0_reg[`RFPX_HDR_PTRHI_MSB:`RFPX_HDR_PTRHI_LSB], hb1_reg};
    assign pair      = {s0_reg, in_data};
    assign hdr_end   = in_valid && (ph_reg == PH_HDR1);
    assign pay_pos   = pos_reg;

    always @* begin
        stuff = 1'b0;
        if (stf_flag) begin
            if (pos_reg == 16'h0000)
                stuff = 1'b1;
            else if (s0_reg != `RFPX_STUFF_ONE)
                stuff = (pos_reg == 16'h0001) || (pos_reg < sn_reg);
        end
    end

    assign pay_valid = in_valid && (ph_reg == PH_PAY) && !in_row_start && !stuff;

    always @* begin
        ph_next = ph_reg;
        if (in_valid) begin
            if (in_row_start)
                ph_next = PH_HDR1;
            else case (ph_reg)
                PH_HDR1: ph_next = PH_PAY;
                PH_PAY:  ph_next = PH_PAY;
                default: ph_next = PH_IDLE;
            endcase
        end
    end

    always @(posedge clk_sys) begin
        if (!rst_n) begin
            ph_reg  <= PH_IDLE;
            hb0_reg <= 8'h00;
            hb1_reg <= 8'h00;
            pos_reg <= 16'h0000;
            s0_reg  <= 8'h00;
            sn_reg  <= 16'h0000;
        end else begin
            ph_reg <= ph_next;
            if (in_valid && in_row_start) begin
                hb0_reg <= in_data;
                pos_reg <= 16'h0000;
                sn_reg  <= 16'h0000;
            end else if (in_valid && ph_reg == PH_HDR1) begin
                hb1_reg <= in_data;
            end else if (in_valid && ph_reg == PH_PAY) begin
                pos_reg <= pos_reg + 16'h0001;
                if (pos_reg == 16'h0000)
                    s0_reg <= in_data;
                if (pos_reg == 16'h0001)
                    sn_reg <= (pair == `RFPX_STUFF_TWO) ? `RFPX_STUFF_TWO_CNT : pair;
            end
        end
    end
endmodule // rfpx_row_parser

`default_nettype wire

// file: tb/rfpx_extractor_assertions.sv
// Checker for the frame packet extractor, watching its ports only.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ns
`default_nettype none
module rfpx_extractor_chk #(
    parameter NTYPES = 8
) (
    input wire logic              clk_sys,
    input wire logic              rst_n,
    input wire logic              in_valid,
    input wire logic [7:0]        in_data,
    input wire logic              in_row_start,
    input wire logic              in_frame_start,
    input wire logic              in_frame_lost,
    input wire logic              in_row_missing,
    input wire logic              ens_select,
    input wire logic              out_valid,
    input wire logic [7:0]        out_data,
    input wire logic              out_sop,
    input wire logic              out_eop,
    input wire logic [2:0]        out_proto,
    input wire logic [NTYPES-1:0] out_abort,
    input wire logic [NTYPES-1:0] sync_state
);
    logic [1:0] pos_reg;
    logic       err_reg;
    logic       stuff_reg;
    wire        loss  = in_frame_lost | in_row_missing | ens_select;
    wire        hdr_b = in_valid & (in_row_start | pos_reg == 2'h1);
    // ----------------------------------------
    // Row byte position
    // ----------------------------------------
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            pos_reg <= 2'h0;
            err_reg <= 1'b0;
            stuff_reg <= 1'b0;
        end else if (in_valid && in_row_start) begin
            pos_reg <= 2'h1;
            err_reg <= in_data[4];
            stuff_reg <= in_data[3];
        end else if (in_valid && pos_reg != 2'h3) begin
            pos_reg <= pos_reg + 2'h1;
        end
    end
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    a_err_row_drop: assert property (err_reg && in_valid && !in_row_start |=> !out_valid)
        else $error("byte of an errored row was output");
    a_err_desync: assert property (err_reg && hdr_b && !in_row_start |=> sync_state == '0)
        else $error("errored row left a type synchronized");
    a_loss_desync: assert property (loss |=> sync_state == '0 && !out_valid)
        else $error("loss left a type synchronized");
    a_abort_open: assert property (out_abort != '0 |-> (out_abort & ~$past(sync_state)) == '0)
        else $error("abort for a type that had no open packet");
    a_sync_sop: assert property (
        (sync_state & ~$past(sync_state)) != '0 |-> out_valid && out_sop
        && (sync_state & ~$past(sync_state)) == (NTYPES'(1) << out_proto))
        else $error("sync gained without a packet start");
    a_out_synced: assert property (out_valid && out_abort == '0 && !$past(loss) |-> sync_state[out_proto])
        else $error("byte output for an unsynchronized type");
    a_byte_echo: assert property (out_valid |-> $past(in_valid) && out_data == $past(in_data))
        else $error("output byte differs from input byte");
    a_hdr_hidden: assert property (hdr_b |=> !out_valid)
        else $error("row header byte was output");
    a_stuff_drop: assert property (stuff_reg && in_valid && !in_row_start && pos_reg == 2'h2 |=> !out_valid)
        else $error("stuffing byte was output");
    c_packet_end: cover property (out_valid && out_eop);
    c_abort: cover property (out_abort != '0);
    c_stuffed: cover property (stuff_reg && in_valid && pos_reg == 2'h2);
endmodule // rfpx_extractor_chk
`default_nettype wire

// file: tb/rfpx_row_src.sv
// Upstream decoder model: sends checked rows one byte per cycle.
// Assumes the bench fills q with the row payload before calling row.
`timescale 1ns/1ns
`default_nettype none
module rfpx_row_src (
    input  wire logic       clk_sys,
    output var  logic       in_valid,
    output var  logic [7:0] in_data,
    output var  logic       in_row_start,
    output var  logic       in_frame_start
);
    logic [7:0] q[$];
    initial begin
        in_valid = 1'b0;
        in_data = 8'h00;
        in_row_start = 1'b0;
        in_frame_start = 1'b0;
    end
    task automatic row(input logic [15:0] hdr, input logic f);
        logic [7:0] b[$];
        b = {hdr[15:8], hdr[7:0], q};
        q.delete();
        for (int j = 0; j < b.size(); j++) begin
            @(negedge clk_sys);
            in_valid = 1'b1;
            in_data = b[j];
            in_row_start = (j == 0);
            in_frame_start = f && (j == 0);
        end
        @(negedge clk_sys);
        in_valid = 1'b0;
        in_row_start = 1'b0;
        in_frame_start = 1'b0;
        // Idle bus shows the inverse, so a stale byte is never mistaken for data
        in_data = ~in_data;
    endtask
endmodule // rfpx_row_src
`default_nettype wire

// file: tb/tb.sv
// Testbench for the frame packet extractor: row sequences, expected bytes.
// Assumes the row source model and the checker are compiled first.
`timescale 1ns/1ns
`default_nettype none
module tb;
    wire         in_valid, in_row_start, in_frame_start, out_valid, out_sop, out_eop;
    wire [7:0]   in_data, out_data, out_abort, sync_state;
    wire [2:0]   out_proto;
    logic        clk_sys, rst_n, in_frame_lost, in_row_missing, ens_select;
    logic [15:0] got[$], exp_q[$];
    logic [7:0]  abort_seen;
    int          miscompares, cmp_count, i, k;
    rfpx_row_src i_src (.clk_sys, .in_valid, .in_data, .in_row_start, .in_frame_start);
    rfpx_extractor i_dut (.clk_sys, .rst_n, .in_valid, .in_data, .in_row_start, .in_frame_start,
        .in_frame_lost, .in_row_missing, .ens_select, .out_valid, .out_data, .out_sop, .out_eop,
        .out_proto, .out_abort, .sync_state);
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        if (out_valid === 1'b1) got.push_back({3'h0, out_proto, out_sop, out_eop, out_data});
        abort_seen <= abort_seen | out_abort;
    end
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [15:0] h(input logic [2:0] t, input logic e, s, input logic [10:0] p);
        return {t, e, s, p};
    endfunction
    task automatic pk(input logic [2:0] t, input logic [7:0] l, s, input int a, b, input logic e);
        logic [7:0] v;
        for (int j = a; j < b; j++) begin
            v = (j == 2) ? 8'h00 : (j == 3) ? l : s + 8'(j);
            i_src.q.push_back(v);
            if (e) exp_q.push_back({3'h0, t, j == 0, j == int'(l) - 1, v});
        end
    endtask
    task cmp(input logic [15:0] g, e);
        cmp_count++;
        if (g !== e) begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task drain;
        repeat (3) @(negedge clk_sys);
        cmp(16'(got.size()), 16'(exp_q.size()));
        while (got.size() > 0 && exp_q.size() > 0) cmp(got.pop_front(), exp_q.pop_front());
        got.delete();
        exp_q.delete();
    endtask
    task end_of_test;
        $display("miscompares %0d comparisons %0d", miscompares, cmp_count);
        if (miscompares == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial begin
        {rst_n, in_frame_lost, in_row_missing, ens_select, abort_seen} = 12'h000;
        miscompares = 0;
        cmp_count = 0;
        repeat (12) @(negedge clk_sys);
        cmp({out_abort, sync_state}, 16'h0000);
        rst_n = 1'b1;
        i_src.q = {8'h5a, 8'h5b};
        pk(3'h0, 8'h06, 8'ha0, 0, 6, 1'b1);
        pk(3'h0, 8'h05, 8'hc0, 0, 4, 1'b1);
        i_src.row(h(3'h0, 1'b0, 1'b0, 11'h002), 1'b1);
        // 186 filler rows complete the 187-row frame so the wrap is judged against a whole frame
        for (i = 1; i < 187; i++) i_src.row(h(3'h3, 1'b0, 1'b0, 11'h7ff), 1'b0);
        pk(3'h0, 8'h05, 8'hc0, 4, 5, 1'b1);
        i_src.row(h(3'h0, 1'b0, 1'b0, 11'h7ff), 1'b1);
        drain;
        cmp({8'h00, sync_state}, 16'h0001);
        for (k = 0; k < 3; k++) begin
            if (k == 0) i_src.q = {8'hff};
            else if (k == 1) i_src.q = {8'hfe, 8'hff};
            else i_src.q = {8'h00, 8'h03, 8'h77};
            pk(3'h0, 8'h04, 8'h10 + 8'(k), 0, 4, 1'b1);
            i_src.row(h(3'h0, 1'b0, 1'b1, 11'(k + 1)), 1'b0);
        end
        drain;
        pk(3'h1, 8'h08, 8'h40, 0, 3, 1'b0);
        i_src.row(h(3'h1, 1'b0, 1'b0, 11'h7ff), 1'b0);
        pk(3'h1, 8'h08, 8'h50, 0, 5, 1'b1);
        i_src.row(h(3'h1, 1'b0, 1'b0, 11'h000), 1'b0);
        pk(3'h0, 8'h04, 8'h60, 0, 4, 1'b1);
        i_src.row(h(3'h0, 1'b0, 1'b0, 11'h000), 1'b0);
        pk(3'h1, 8'h08, 8'h50, 5, 8, 1'b1);
        i_src.row(h(3'h1, 1'b0, 1'b0, 11'h7ff), 1'b0);
        drain;
        cmp({8'h00, sync_state}, 16'h0003);
        pk(3'h1, 8'h08, 8'h70, 0, 4, 1'b1);
        i_src.row(h(3'h1, 1'b0, 1'b0, 11'h000), 1'b0);
        abort_seen = 8'h00;
        pk(3'h2, 8'h04, 8'h80, 0, 4, 1'b0);
        i_src.row(h(3'h2, 1'b1, 1'b0, 11'h000), 1'b0);
        pk(3'h1, 8'h08, 8'h70, 4, 8, 1'b0);
        i_src.row(h(3'h1, 1'b0, 1'b0, 11'h7ff), 1'b0);
        drain;
        cmp({abort_seen, sync_state}, 16'h0200);
        // Lost frame, missing row, new ensemble, short frame, then a bad length
        for (k = 0; k < 5; k++) begin
            abort_seen = 8'h00;
            pk(3'h0, (k == 4) ? 8'h00 : 8'h08, 8'h90, 0, 4, 1'b1);
            i_src.row(h(3'h0, 1'b0, 1'b0, 11'h000), 1'b0);
            if (k < 3) begin
                {ens_select, in_row_missing, in_frame_lost} = 3'h1 << k;
                @(negedge clk_sys);
                {ens_select, in_row_missing, in_frame_lost} = 3'h0;
            end else if (k == 3) begin
                i_src.row(h(3'h0, 1'b0, 1'b0, 11'h7ff), 1'b1);
            end
            drain;
            cmp({abort_seen, sync_state}, 16'h0100);
        end
        end_of_test;
    end
    initial begin
        #100000;
        miscompares++;
        end_of_test;
    end
endmodule // tb
bind rfpx_extractor rfpx_extractor_chk #(.NTYPES(NTYPES)) i_chk (.clk_sys, .rst_n, .in_valid, .in_data,
    .in_row_start, .in_frame_start, .in_frame_lost, .in_row_missing, .ens_select, .out_valid, .out_data,
    .out_sop, .out_eop, .out_proto, .out_abort, .sync_state);
`default_nettype wire
